// ==== bench/mcp_chk.sv ====
// Assertion checker for the code protection block
`timescale 1ns/1ns
module mcp_chk (
  input wire        clk_sys,
  input wire        rst,
  input wire        prog_mem_protect_n,
  input wire        eeprom_protect_n,
  input wire        app_region_write_guard,
  input wire        storage_area_write_guard,
  input wire        boot_region_write_guard,
  input wire        config_region_write_guard,
  input wire        ext_space,
  input wire [13:0] ext_rdata,
  input wire        ext_ack,
  input wire        ext_refused,
  input wire        cpu_we,
  input wire        cpu_space,
  input wire [15:0] cpu_addr,
  input wire        cpu_ack,
  input wire        cpu_wr_blocked,
  input wire        mem_req
);
  reg [5:0] cfg_q;
  ////////////////////////////////////////
  // Configuration as captured in reset
  always @(posedge clk_sys)
    if (rst)
      cfg_q <= {config_region_write_guard, boot_region_write_guard, storage_area_write_guard,
                app_region_write_guard, eeprom_protect_n, prog_mem_protect_n};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_ext_prog;
    $rose(ext_ack) && !ext_space && !cfg_q[0] |-> ext_refused && ext_rdata == 14'h0000;
  endproperty
  a_ext_prog: assert property (p_ext_prog)
    else $error("program access not refused");
  property p_ext_eep;
    $rose(ext_ack) && ext_space && !cfg_q[1] |-> ext_refused && ext_rdata == 14'h0000;
  endproperty
  a_ext_eep: assert property (p_ext_eep)
    else $error("eeprom access not refused");
  property p_ext_indep;
    $rose(ext_ack) && ext_space && cfg_q[1] |-> !ext_refused;
  endproperty
  a_ext_indep: assert property (p_ext_indep)
    else $error("open eeprom refused");
  property p_cpu_read;
    cpu_ack && !cpu_we |-> !cpu_wr_blocked;
  endproperty
  a_cpu_read: assert property (p_cpu_read)
    else $error("cpu read blocked");
  property p_cpu_uid;
    cpu_ack && !cpu_space && cpu_addr[15:2] == 14'h2000 |-> !cpu_wr_blocked;
  endproperty
  a_cpu_uid: assert property (p_cpu_uid)
    else $error("user id blocked");
  property p_boot;
    cpu_ack && cpu_we && !cpu_space && cpu_addr <= 16'h07ff && cfg_q[4] |-> cpu_wr_blocked;
  endproperty
  a_boot: assert property (p_boot)
    else $error("guarded boot write passed");
  property p_open;
    cpu_ack && cpu_we && !cpu_space && cfg_q[5:2] == 4'h0 |-> !cpu_wr_blocked;
  endproperty
  a_open: assert property (p_open)
    else $error("unguarded write blocked");
  property p_blk_nomem;
    cpu_ack && cpu_wr_blocked |-> !$past(mem_req) && !$past(mem_req, 2);
  endproperty
  a_blk_nomem: assert property (p_blk_nomem)
    else $error("blocked write reached memory");
endmodule

bind mcp_code_protect mcp_chk i_chk (.*);

// ==== bench/mcp_code_protect_tb_top.sv ====
// Self-checking testbench of the code protection block
`timescale 1ns/1ns
`include "mcp_regs.vh"
module mcp_code_protect_tb_top;
  logic        clk_sys, rst, por_rst, mem_viol_rst, vbat_bor_rst, irq;
  logic        prog_mem_protect_n, eeprom_protect_n, app_region_write_guard;
  logic        storage_area_write_guard, boot_region_write_guard, config_region_write_guard;
  logic        psel, penable, pwrite, pready, pslverr, f, xf;
  logic        ext_req, ext_we, ext_space, ext_ack, ext_refused;
  logic        cpu_req, cpu_we, cpu_space, cpu_ack, cpu_wr_blocked;
  logic        mem_req, mem_we, mem_space, mem_ack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, d;
  logic [15:0] ext_addr, cpu_addr, mem_addr;
  logic [13:0] ext_wdata, ext_rdata, cpu_wdata, cpu_rdata, mem_wdata, mem_rdata, xd;
  logic [3:0]  lat;
  logic [5:0]  cf, pins;
  logic [13:0] mdl [int];
  logic [15:0] rg [4] = '{16'h0900, 16'h1f90, 16'h0010, 16'h8008};
  integer      err_total, n_compared, seed, i;
  integer      cyc = 0;

  mcp_code_protect i_dut (.*);
  mcp_mem_model i_mem (.*);
  assign {config_region_write_guard, boot_region_write_guard, storage_area_write_guard,
          app_region_write_guard, eeprom_protect_n, prog_mem_protect_n} = pins;
  ////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total = err_total + 1;
      test_done;
    end
  end
  // Checking and closing
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_flag(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task test_done;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Port drivers
  task do_reset(input logic [5:0] c, input logic p);
    @(posedge clk_sys);
    {rst, por_rst, pins} <= {1'b1, p, c};
    cf = c;
    repeat (10) @(posedge clk_sys);
    {rst, por_rst} <= 2'b00;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] v, output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, v};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, q, f);
    chk(q, e);
  endtask
  task cpu(input logic w, s, input logic [15:0] a, input logic [13:0] v);
    @(posedge clk_sys);
    {cpu_req, cpu_we, cpu_space, cpu_addr, cpu_wdata} <= {1'b1, w, s, a, v};
    do @(posedge clk_sys); while (cpu_ack !== 1'b1);
    cpu_req <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task ext(input logic w, s, input logic [15:0] a, input logic [13:0] v);
    @(posedge clk_sys);
    {ext_req, ext_we, ext_space, ext_addr, ext_wdata} <= {1'b1, w, s, a, v};
    do @(posedge clk_sys); while (ext_ack !== 1'b1);
    xd = ext_rdata;
    xf = ext_refused;
    ext_req <= 1'b0;
    do @(posedge clk_sys); while (ext_ack !== 1'b0);
  endtask
  // One access on either port, predicted by the model
  task xfer(input logic p, w, s, input logic [15:0] a, input logic [13:0] v);
    logic b;
    b = p ? (s ? !cf[1] : !cf[0]) : w && !s && (a <= `MCP_BOOT_LAST ? cf[4] :
        a >= `MCP_SAF_FIRST && a <= `MCP_SAF_LAST ? cf[3] :
        a >= `MCP_CONF_FIRST && a <= `MCP_CONF_LAST ? cf[5] : a < `MCP_UID_FIRST && cf[2]);
    lat <= 4'($random(seed));
    if (p)
      ext(w, s, a, v);
    else
      cpu(w, s, a, v);
    chk_flag(p ? xf : cpu_wr_blocked, b);
    if (!w)
      chk({18'h0, p ? xd : cpu_rdata}, {18'h0, b ? 14'h0000 : mdl[{s, a}]});
    if (w && !b)
      mdl[{s, a}] = v;
  endtask
  task pulse(input logic v);
    @(posedge clk_sys);
    {vbat_bor_rst, mem_viol_rst} <= {v, !v};
    @(posedge clk_sys);
    {vbat_bor_rst, mem_viol_rst} <= 2'b00;
    repeat (3) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    seed = 33130;
    err_total = 0;
    n_compared = 0;
    {rst, lat, pins, cf} = {1'b1, 16'h0};
    {por_rst, mem_viol_rst, vbat_bor_rst, psel, penable, pwrite, paddr, pwdata, ext_req, ext_we, ext_space,
     ext_addr, ext_wdata, cpu_req, cpu_we, cpu_space, cpu_addr, cpu_wdata} = '0;
    do_reset(6'h02, 1'b1);
    rd(`MCP_OFF_PWR_STATUS, 32'h3);
    rd(`MCP_OFF_CFG_STATUS, 32'h2);
    d = $random(seed);
    xfer(1, 1, 0, 16'h0120, d[13:0]);
    xfer(1, 0, 0, 16'h0120, 14'h0);
    xfer(1, 1, 1, 16'h0033, {6'h0, d[7:0]});
    xfer(1, 0, 1, 16'h0033, 14'h0);
    $display("Test external gating done");
    xfer(0, 1, 0, 16'h0010, d[13:0]);
    xfer(0, 1, 0, 16'h0120, d[27:14]);
    xfer(0, 0, 0, 16'h0120, 14'h0);
    xfer(0, 1, 1, 16'h0044, {6'h0, d[15:8]});
    xfer(0, 0, 1, 16'h0044, 14'h0);
    for (i = 0; i < 4; i++)
    begin
      xfer(0, 1, 0, 16'h8000 + i[15:0], d[20:7] ^ i[13:0]);
      xfer(0, 0, 0, 16'h8000 + i[15:0], 14'h0);
    end
    pins[0] <= 1'b1;
    xfer(1, 0, 0, 16'h0120, 14'h0);
    $display("Test processor access done");
    do_reset(6'b111101, 1'b0);
    rd(`MCP_OFF_PWR_STATUS, 32'h3);
    for (i = 0; i < 4; i++)
      xfer(0, 1, 0, rg[i], d[13:0]);
    xfer(0, 1, 0, 16'h8003, d[29:16]);
    xfer(1, 0, 0, 16'h0120, 14'h0);
    xfer(1, 0, 1, 16'h0033, 14'h0);
    $display("Test region guards done");
    apb(1'b1, `MCP_OFF_INT_STATUS, 32'hf, q, f);
    apb(1'b1, `MCP_OFF_INT_MASK, 32'h4, q, f);
    pulse(1'b0);
    chk_flag(irq, 1'b1);
    rd(`MCP_OFF_PWR_STATUS, 32'h1);
    rd(`MCP_OFF_INT_STATUS, 32'h4);
    apb(1'b1, `MCP_OFF_INT_STATUS, 32'h4, q, f);
    apb(1'b1, `MCP_OFF_PWR_STATUS, 32'h3, q, f);
    pulse(1'b1);
    chk_flag(irq, 1'b0);
    rd(`MCP_OFF_PWR_STATUS, 32'h2);
    rd(`MCP_OFF_INT_STATUS, 32'h8);
    apb(1'b1, 12'h010, 32'h0, q, f);
    chk_flag(f, 1'b1);
    $display("Test status and interrupt done");
    test_done;
  end
endmodule

// ==== bench/mcp_mem_model.sv ====
// Behavioural program flash and data EEPROM behind the memory port
`timescale 1ns/1ns
module mcp_mem_model (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        mem_req,
  input  wire        mem_we,
  input  wire        mem_space,
  input  wire [15:0] mem_addr,
  input  wire [13:0] mem_wdata,
  output reg  [13:0] mem_rdata,
  output reg         mem_ack,
  input  wire [3:0]  lat
);
  reg [13:0] arr [0:16383];
  reg [3:0]  cnt_q;
  reg        busy_q;
  ////////////////////////////////////////
  // One answer per request after lat idle cycles; data toggles when idle
  always @(posedge clk_sys)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (rst)
      busy_q <= 1'b0;
    else if (mem_req)
    begin
      busy_q <= 1'b1;
      cnt_q <= lat;
    end
    else if (busy_q && cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
    else if (busy_q)
    begin
      busy_q <= 1'b0;
      mem_ack <= 1'b1;
      mem_rdata <= arr[{mem_space, mem_addr[12:0]}];
      if (mem_we)
        arr[{mem_space, mem_addr[12:0]}] <= mem_wdata;
    end
  end
  initial
    mem_rdata = 14'h0000;
endmodule

// ==== logic/mcp_code_protect.v ====
// Code protection gate between external programmer, CPU and the program flash / data EEPROM
`timescale 1ns/1ns
`include "mcp_regs.vh"

module mcp_code_protect
(
  input  wire        clk_sys,
  input  wire        rst,
  // Power-on reset cause, valid while rst is high
  input  wire        por_rst,
  // Reset cause pulses from the reset controller
  input  wire        mem_viol_rst,
  input  wire        vbat_bor_rst,
  // Configuration word bits from configuration memory
  input  wire        prog_mem_protect_n,
  input  wire        eeprom_protect_n,
  input  wire        app_region_write_guard,
  input  wire        storage_area_write_guard,
  input  wire        boot_region_write_guard,
  input  wire        config_region_write_guard,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq,
  // External programmer port (pins, four-phase handshake)
  input  wire        ext_req,
  input  wire        ext_we,
  input  wire        ext_space,
  input  wire [15:0] ext_addr,
  input  wire [13:0] ext_wdata,
  output reg  [13:0] ext_rdata,
  output reg         ext_ack,
  output reg         ext_refused,
  // CPU port
  input  wire        cpu_req,
  input  wire        cpu_we,
  input  wire        cpu_space,
  input  wire [15:0] cpu_addr,
  input  wire [13:0] cpu_wdata,
  output reg  [13:0] cpu_rdata,
  output reg         cpu_ack,
  output reg         cpu_wr_blocked,
  // Memory array port
  output reg         mem_req,
  output reg         mem_we,
  output reg         mem_space,
  output reg  [15:0] mem_addr,
  output reg  [13:0] mem_wdata,
  input  wire [13:0] mem_rdata,
  input  wire        mem_ack
);

  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_WAIT = 4'b0010;
  localparam [3:0] S_DONE = 4'b0100;
  localparam [3:0] S_REL  = 4'b1000;

  // True when a program address lies inside [lo, hi]
  function in_range;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State
  reg  [3:0]  state_q;
  reg  [3:0]  state_d;
  reg         owner_ext_q;
  reg  [5:0]  cfg_q;
  reg  [1:0]  pwr_q;
  reg  [3:0]  int_stat_q;
  reg  [3:0]  int_mask_q;
  reg  [13:0] uid_mem [0:3];
  reg  [1:0]  ext_req_m;
  reg         ext_req_s;
  reg  [33:0] ext_bus_m;
  reg  [33:0] ext_bus_s;

  wire        ext_req_sync = ext_req_s;
  wire        ext_we_s     = ext_bus_s[33];
  wire        ext_space_s  = ext_bus_s[32];
  wire [15:0] ext_addr_s   = ext_bus_s[31:16];
  wire [13:0] ext_wdata_s  = ext_bus_s[13:0];

  //////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the programmer pins
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      ext_req_m <= 2'b00;
      ext_req_s <= 1'b0;
      ext_bus_m <= 34'h0;
      ext_bus_s <= 34'h0;
    end
    else
    begin
      ext_req_m <= {ext_req_m[0], ext_req};
      // Extra stage keeps the request one cycle behind the settled bus
      ext_req_s <= ext_req_m[1];
      ext_bus_m <= {ext_we, ext_space, ext_addr, 2'b00, ext_wdata};
      ext_bus_s <= ext_bus_m;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Request decode and permission check
  reg         sel_ext;
  reg         sel_we;
  reg         sel_space;
  reg  [15:0] sel_addr;
  reg  [13:0] sel_wdata;
  reg         sel_uid;
  reg         refuse;
  reg         guard_hit;

  always @*
  begin
    sel_ext   = ~cpu_req & ext_req_sync;
    sel_we    = sel_ext ? ext_we_s    : cpu_we;
    sel_space = sel_ext ? ext_space_s : cpu_space;
    sel_addr  = sel_ext ? ext_addr_s  : cpu_addr;
    sel_wdata = sel_ext ? ext_wdata_s : cpu_wdata;
    sel_uid   = (sel_space == `MCP_SPACE_PROG) && in_range(sel_addr, `MCP_UID_FIRST, `MCP_UID_LAST);
    // Region guards only look at program space self-writes
    guard_hit = 1'b0;
    if (sel_space == `MCP_SPACE_PROG)
    begin
      if (in_range(sel_addr, `MCP_BOOT_FIRST, `MCP_BOOT_LAST))
        guard_hit = cfg_q[`MCP_CFG_BOOT_BIT];
      else if (in_range(sel_addr, `MCP_SAF_FIRST, `MCP_SAF_LAST))
        guard_hit = cfg_q[`MCP_CFG_SAF_BIT];
      else if (in_range(sel_addr, `MCP_CONF_FIRST, `MCP_CONF_LAST))
        guard_hit = cfg_q[`MCP_CFG_CONF_BIT];
      else if (sel_addr < `MCP_UID_FIRST)
        guard_hit = cfg_q[`MCP_CFG_APP_BIT];
    end
    if (sel_ext)
      // Separate protect bit per memory space
      refuse = (sel_space == `MCP_SPACE_PROG) ? ~cfg_q[`MCP_CFG_PROG_BIT]
                                              : ~cfg_q[`MCP_CFG_EEP_BIT];
    else
      // CPU reads always pass; EEPROM always writable; user IDs always writable
      refuse = sel_we & ~sel_uid & guard_hit;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always @*
  begin
    case (state_q)
      S_IDLE:
      begin
        if ((cpu_req || ext_req_sync) && (refuse || sel_uid))
          state_d = sel_ext ? S_REL : S_DONE;
        else if (cpu_req || ext_req_sync)
          state_d = S_WAIT;
        else
          state_d = S_IDLE;
      end
      S_WAIT:
      begin
        if (mem_ack)
          state_d = owner_ext_q ? S_REL : S_DONE;
        else
          state_d = S_WAIT;
      end
      S_DONE:
        state_d = S_IDLE;
      S_REL:
        state_d = ext_req_sync ? S_REL : S_IDLE;
      default:
        state_d = S_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Access engine and user ID words
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q        <= S_IDLE;
      owner_ext_q    <= 1'b0;
      mem_req        <= 1'b0;
      mem_we         <= 1'b0;
      mem_space      <= 1'b0;
      mem_addr       <= 16'h0000;
      mem_wdata      <= 14'h0000;
      cpu_rdata      <= 14'h0000;
      cpu_ack        <= 1'b0;
      cpu_wr_blocked <= 1'b0;
      ext_rdata      <= 14'h0000;
      ext_ack        <= 1'b0;
      ext_refused    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      mem_req <= 1'b0;
      cpu_ack <= 1'b0;
      if (state_q == S_IDLE && (cpu_req || ext_req_sync))
      begin
        owner_ext_q <= sel_ext;
        if (refuse)
        begin
          // Refused access: no memory cycle, read data forced to zero
          if (sel_ext)
          begin
            ext_rdata   <= 14'h0000;
            ext_refused <= 1'b1;
            ext_ack     <= 1'b1;
          end
          else
          begin
            cpu_rdata      <= 14'h0000;
            cpu_wr_blocked <= 1'b1;
            cpu_ack        <= 1'b1;
          end
        end
        else if (sel_uid)
        begin
          if (sel_we)
            uid_mem[sel_addr[1:0]] <= sel_wdata;
          if (sel_ext)
          begin
            ext_rdata   <= uid_mem[sel_addr[1:0]];
            ext_refused <= 1'b0;
            ext_ack     <= 1'b1;
          end
          else
          begin
            cpu_rdata      <= uid_mem[sel_addr[1:0]];
            cpu_wr_blocked <= 1'b0;
            cpu_ack        <= 1'b1;
          end
        end
        else
        begin
          mem_req   <= 1'b1;
          mem_we    <= sel_we;
          mem_space <= sel_space;
          mem_addr  <= sel_addr;
          mem_wdata <= sel_wdata;
        end
      end
      else if (state_q == S_WAIT && mem_ack)
      begin
        if (owner_ext_q)
        begin
          ext_rdata   <= mem_rdata;
          ext_refused <= 1'b0;
          ext_ack     <= 1'b1;
        end
        else
        begin
          cpu_rdata      <= mem_rdata;
          cpu_wr_blocked <= 1'b0;
          cpu_ack        <= 1'b1;
        end
      end
      else if (state_q == S_REL && !ext_req_sync)
        ext_ack <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration capture, held until the next reset
  always @(posedge clk_sys)
  begin
    if (rst)
      cfg_q <= {config_region_write_guard, boot_region_write_guard,
                storage_area_write_guard, app_region_write_guard,
                eeprom_protect_n, prog_mem_protect_n};
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB access strobes
  wire       apb_acc  = psel & penable;
  wire       apb_wr   = apb_acc & pready & pwrite;
  wire [3:0] int_ev   = {~pwr_q[`MCP_PWR_VBAT_BIT] ? 1'b0 : vbat_bor_rst,
                         ~pwr_q[`MCP_PWR_MEMORY_VIOLATION_FLAG_N_BIT] ? 1'b0 : mem_viol_rst,
                         (state_q == S_IDLE) & (cpu_req | ext_req_sync) & refuse & ~sel_ext,
                         (state_q == S_IDLE) & ext_req_sync & ~cpu_req & refuse};

  //////////////////////////////////////////////////////////////////////////////
  // power_reset_status_one: hardware clear wins over a firmware write
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      if (por_rst)
        pwr_q <= `MCP_PWR_RST;
    end
    else
    begin
      if (mem_viol_rst)
        pwr_q[`MCP_PWR_MEMORY_VIOLATION_FLAG_N_BIT] <= 1'b0;
      else if (apb_wr && paddr == `MCP_OFF_PWR_STATUS)
        pwr_q[`MCP_PWR_MEMORY_VIOLATION_FLAG_N_BIT] <= pwdata[`MCP_PWR_MEMORY_VIOLATION_FLAG_N_BIT];
      if (vbat_bor_rst)
        pwr_q[`MCP_PWR_VBAT_BIT] <= 1'b0;
      else if (apb_wr && paddr == `MCP_OFF_PWR_STATUS)
        pwr_q[`MCP_PWR_VBAT_BIT] <= pwdata[`MCP_PWR_VBAT_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status (write one to clear, set wins) and mask
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      int_stat_q <= 4'h0;
      int_mask_q <= `MCP_INT_MASK_RST;
      irq        <= 1'b0;
    end
    else
    begin
      if (apb_wr && paddr == `MCP_OFF_INT_STATUS)
        int_stat_q <= (int_stat_q & ~pwdata[3:0]) | int_ev;
      else
        int_stat_q <= int_stat_q | int_ev;
      if (apb_wr && paddr == `MCP_OFF_INT_MASK)
        int_mask_q <= pwdata[3:0];
      irq <= |(int_stat_q & int_mask_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB answer: one wait state, ready on the second access cycle
  reg [31:0] rd_mux;
  reg        rd_bad;

  always @*
  begin
    rd_bad = 1'b0;
    case (paddr)
      `MCP_OFF_PWR_STATUS: rd_mux = {30'h0, pwr_q};
      `MCP_OFF_CFG_STATUS: rd_mux = {26'h0, cfg_q};
      `MCP_OFF_INT_STATUS: rd_mux = {28'h0, int_stat_q};
      `MCP_OFF_INT_MASK:   rd_mux = {28'h0, int_mask_q};
      default:
      begin
        rd_mux = 32'h0;
        rd_bad = 1'b1;
      end
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= apb_acc & ~pready;
      pslverr <= apb_acc & ~pready & (rd_bad | (pwrite && paddr == `MCP_OFF_CFG_STATUS));
      prdata  <= (apb_acc & ~pready & ~pwrite) ? rd_mux : 32'h0;
    end
  end

endmodule

// ==== logic/mcp_regs.vh ====
// Register map, field positions, reset values and address ranges of the code protection block
`ifndef MCP_REGS_VH
`define MCP_REGS_VH

// APB register byte offsets
`define MCP_OFF_PWR_STATUS   12'h000
`define MCP_OFF_CFG_STATUS   12'h004
`define MCP_OFF_INT_STATUS   12'h008
`define MCP_OFF_INT_MASK     12'h00c

// power_reset_status_one fields
`define MCP_PWR_VBAT_BIT     0
`define MCP_PWR_MEMORY_VIOLATION_FLAG_N_BIT     1
`define MCP_PWR_WIDTH        2
`define MCP_PWR_RST          2'b11

// Latched configuration status fields
`define MCP_CFG_PROG_BIT     0
`define MCP_CFG_EEP_BIT      1
`define MCP_CFG_APP_BIT      2
`define MCP_CFG_SAF_BIT      3
`define MCP_CFG_BOOT_BIT     4
`define MCP_CFG_CONF_BIT     5

// Interrupt status and mask fields
`define MCP_INT_EXT_REFUSED  0
`define MCP_INT_CPU_BLOCKED  1
`define MCP_INT_MEMORY_VIOLATION_FLAG_N         2
`define MCP_INT_VBAT_BOR     3
`define MCP_INT_WIDTH        4
`define MCP_INT_MASK_RST     4'h0

// Program memory regions
`define MCP_BOOT_FIRST       16'h0000
`define MCP_BOOT_LAST        16'h07ff
`define MCP_SAF_FIRST        16'h1f80
`define MCP_SAF_LAST         16'h1fff
`define MCP_UID_FIRST        16'h8000
`define MCP_UID_LAST         16'h8003
`define MCP_CONF_FIRST       16'h8007
`define MCP_CONF_LAST        16'h800b

// Memory spaces
`define MCP_SPACE_PROG       1'b0
`define MCP_SPACE_EEP        1'b1

`endif
